// ===== common/pll_adj_pkg.sv
package pll_adj_pkg;

  // ----------------------------------------------------------------
  // register map (word indices, byte address is index times four, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_LOOP = 4'h0;
  localparam logic [3:0] ADDR_CTR_SEL = 4'h1;
  localparam logic [3:0] ADDR_CTR_CFG = 4'h2;
  localparam logic [3:0] ADDR_VCO_DIV = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_TAP_SEL = 4'h5;
  localparam logic [3:0] ADDR_TAP = 4'h6;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PUMP_LSB = 0;
  localparam int RES_LSB = 4;
  localparam int CAP_LSB = 12;
  localparam int BYPASS_BIT = 8;
  localparam int ODD_BIT = 9;
  localparam int HIGH_LSB = 16;
  localparam int LOW_LSB = 24;

  // ----------------------------------------------------------------
  // legal codes and select map
  // ----------------------------------------------------------------
  localparam logic [7:0] PUMP_LEGAL = 8'h8B;       // codes 0,1,3,7
  localparam logic [31:0] RES_LEGAL = 32'h5919_0119; // 0,3,4,8,16,19,20,24,27,28,30
  localparam logic [3:0] CAP_LEGAL = 4'hB;         // codes 0,1,3
  localparam logic [3:0] SEL_ALL = 4'h0;
  localparam logic [3:0] SEL_FB = 4'h1;
  localparam logic [3:0] SEL_OUT0 = 4'h2;
  localparam logic [2:0] TAP_STEP = 3'h1;          // one eighth of a period
  localparam int TAP_COUNT = 8;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [8:0] CTR_RESET = 9'h100;      // bypassed
  localparam logic [7:0] DONE_DELAY_CYC = 8'h04;  // internal settle time

  typedef struct packed {
    logic [2:0] pump_current_bits;
    logic [4:0] filter_resistor_bits;
    logic [1:0] filter_capacitor_bits;
  } loop_cfg_type;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic odd;
    logic [8:0] word;   // bit 8 bypass, [7:0] ignored when bypassed
  } ctr_cfg_type;

  typedef struct packed {
    logic up;
    logic [3:0] sel;
  } step_req_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARM = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_WAIT_REL = 4'b1000
  } step_state_type;

endpackage

// ===== rtl/pll_sync_edge.sv
`timescale 1ns/1ps
module pll_sync_edge
  import pll_adj_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // async inputs
  input wire logic [WIDTH-1:0] async_i,
  // synced levels and edges of bit 0
  output logic [WIDTH-1:0] level_o,
  output logic rise_o,
  output logic fall_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic prev_r;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  // edge history of bit 0
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sync_r[0];
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r[0] & ~prev_r;
  assign fall_o = ~sync_r[0] & prev_r;

endmodule

// ===== rtl/pll_tap_mem.sv
`timescale 1ns/1ps
module pll_tap_mem
  import pll_adj_pkg::*;
#(
  parameter int ENTRIES = 12
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // shift command
  input wire logic shift_i,
  input wire logic up_i,
  input wire logic [3:0] sel_i,
  // readback
  input wire logic [3:0] rd_idx_i,
  output logic [2:0] rd_tap_o
);

  logic [2:0] tap_r [ENTRIES];

  // one tap register per counter; entry 1 is feedback, 2.. are outputs
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_tap
      logic hit;
      assign hit = (sel_i == 4'(g)) || ((sel_i == SEL_ALL) && (g >= 2));
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          tap_r[g] <= '0;
        end else if (shift_i && hit && g != 0) begin
          // wraps modulo eight, one tap per step
          tap_r[g] <= up_i ? tap_r[g] + TAP_STEP : tap_r[g] - TAP_STEP;
        end
      end
    end
  endgenerate

  // registered readback
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_tap_o <= '0;
    end else if (rd_idx_i < 4'(ENTRIES)) begin
      rd_tap_o <= tap_r[rd_idx_i];
    end else begin
      rd_tap_o <= '0;
    end
  end

endmodule

// ===== rtl/pll_adjust_ctrl.sv
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - pump current accepts only 000, 001, 011, 111
// - resistor limited to listed eleven codes; capacitor to 0, 1, 3
// - pump and filter settings change at run time, no reconfiguration
// - bypassed feedback multiplies by one; other bypassed counters divide by one
// - counter bit 8 is bypass; when set other bits are ignored
// - oscillator post divider bypasses when its bit is 0
// - phase steps need no scan load; outputs keep toggling
// - each step moves selected tap by one eighth of a period
// - select sampled on scan rising edge: 0 all outputs, 1 feedback, 2..11 outputs
// - outputs 7 to 9 exist only on ten-counter variant
// - direction sampled on scan rising edge: 1 up, 0 down
// - step request captured on scan falling edge, held two cycles
// - second scan rising edge after capture samples inputs, starts shift
// - done drops at that edge, rises after internal shifting time
// - one shift per pulse; pulses a cycle apart; unlimited repeats
// - counter division is high count plus low count when not bypassed
// - odd bit moves half cycle from high to low time
module pll_adjust_ctrl
  import pll_adj_pkg::*;
#(
  parameter int NUM_OUT = 10,
  parameter logic [7:0] DONE_CYC = DONE_DELAY_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // avalon-mm slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // phase-step handshake from core logic
  input wire logic scan_clk_i,
  input wire logic [3:0] phase_sel_i,
  input wire logic phase_up_i,
  input wire logic phase_step_i,
  output logic phase_done_o,
  // applied pll settings
  output loop_cfg_type loop_cfg_o,
  output logic [NUM_OUT+1:0] ctr_bypass_o,
  output logic vco_div_bypass_o,
  output logic shift_pulse_o,
  output step_req_type shift_req_o
);

  localparam int NCTR = NUM_OUT + 2;  // entry 0 input divider, 1 feedback

  // ----------------------------------------------------------------
  // scan clock domain crossing
  // ----------------------------------------------------------------
  logic [6:0] in_sync;
  logic scan_rise;
  logic scan_fall;

  pll_sync_edge #(.WIDTH(7)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({phase_step_i, phase_up_i, phase_sel_i, scan_clk_i}),
    .level_o(in_sync),
    .rise_o(scan_rise),
    .fall_o(scan_fall)
  );

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [3:0] word_addr;
  logic wr_loop, wr_sel, wr_cfg, wr_vco, wr_tsel;
  logic [31:0] wdata_m;
  loop_cfg_type loop_r;
  logic [3:0] ctr_sel_r;
  logic [3:0] tap_sel_r;
  ctr_cfg_type ctr_r [NCTR];
  logic vco_bit_r;
  logic rd_pend_r;
  logic [31:0] rdata_nxt;
  logic [2:0] tap_rd;
  logic [3:0] last_sel_r;
  logic last_up_r;
  logic bad_code_r;

  assign word_addr = avs_address_i[ADDR_LSB +: 4];
  // reads take two cycles so tap memory data come from its register
  assign avs_waitrequest_o = avs_read_i & ~rd_pend_r;

  // byte enables merged into the write word
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wdata_m[b*8 +: 8] = avs_byteenable_i[b] ? avs_writedata_i[b*8 +: 8] : 8'h00;
    end
  end

  // address decode
  always_comb begin
    wr_loop = 1'b0;
    wr_sel = 1'b0;
    wr_cfg = 1'b0;
    wr_vco = 1'b0;
    wr_tsel = 1'b0;
    if (avs_write_i && word_addr == ADDR_LOOP) begin
      wr_loop = 1'b1;
    end else if (avs_write_i && word_addr == ADDR_CTR_SEL) begin
      wr_sel = 1'b1;
    end else if (avs_write_i && word_addr == ADDR_CTR_CFG) begin
      wr_cfg = 1'b1;
    end else if (avs_write_i && word_addr == ADDR_VCO_DIV) begin
      wr_vco = 1'b1;
    end else if (avs_write_i && word_addr == ADDR_TAP_SEL) begin
      wr_tsel = 1'b1;
    end
  end

  // loop bandwidth: only legal codes land, applied live
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loop_r <= '0;
      bad_code_r <= 1'b0;
    end else if (wr_loop) begin
      if (PUMP_LEGAL[wdata_m[PUMP_LSB +: 3]] && RES_LEGAL[wdata_m[RES_LSB +: 5]] &&
          CAP_LEGAL[wdata_m[CAP_LSB +: 2]]) begin
        loop_r.pump_current_bits <= wdata_m[PUMP_LSB +: 3];
        loop_r.filter_resistor_bits <= wdata_m[RES_LSB +: 5];
        loop_r.filter_capacitor_bits <= wdata_m[CAP_LSB +: 2];
        bad_code_r <= 1'b0;
      end else begin
        bad_code_r <= 1'b1;  // rejected write keeps old settings
      end
    end
  end

  // counter index and tap readback select
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctr_sel_r <= '0;
      tap_sel_r <= '0;
    end else begin
      if (wr_sel) begin
        ctr_sel_r <= wdata_m[3:0];
      end
      if (wr_tsel) begin
        tap_sel_r <= wdata_m[3:0];
      end
    end
  end

  // per counter settings
  genvar g;
  generate
    for (g = 0; g < NCTR; g++) begin : g_ctr
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ctr_r[g] <= '{low: 8'h00, high: 8'h00, odd: 1'b0, word: CTR_RESET};
        end else if (wr_cfg && ctr_sel_r == 4'(g)) begin
          ctr_r[g].word <= wdata_m[8:0];
          ctr_r[g].odd <= wdata_m[ODD_BIT];
          ctr_r[g].high <= wdata_m[HIGH_LSB +: 8];
          ctr_r[g].low <= wdata_m[LOW_LSB +: 8];
        end
      end
      // bypass bit alone decides; other bits ignored when set
      assign ctr_bypass_o[g] = ctr_r[g].word[BYPASS_BIT];
    end
  endgenerate

  // oscillator post divider has inverted sense
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vco_bit_r <= 1'b1;
    end else if (wr_vco) begin
      vco_bit_r <= wdata_m[0];
    end
  end
  assign vco_div_bypass_o = ~vco_bit_r;
  assign loop_cfg_o = loop_r;

  // ----------------------------------------------------------------
  // phase step handshake
  // ----------------------------------------------------------------
  step_state_type state_r;
  step_state_type state_nxt;
  logic [1:0] rise_cnt_r;
  logic [7:0] done_cnt_r;
  logic done_r;
  logic shift_go;
  logic sel_ok;

  // unimplemented select codes never shift anything
  assign sel_ok = in_sync[4:1] < 4'(NCTR);
  assign shift_go = (state_r == ST_ARM) && scan_rise && rise_cnt_r == 2'd1;

  // handshake state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (scan_fall && in_sync[6]) begin
          state_nxt = ST_ARM;
        end
      end
      ST_ARM: begin
        if (shift_go) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (done_cnt_r == 8'd0) begin
          state_nxt = ST_WAIT_REL;
        end
      end
      ST_WAIT_REL: begin
        // a step still held is not a new pulse
        if (!in_sync[6]) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // scan rising edges counted from capture
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_cnt_r <= '0;
    end else if (state_r != ST_ARM) begin
      rise_cnt_r <= '0;
    end else if (scan_rise) begin
      rise_cnt_r <= rise_cnt_r + 2'd1;
    end
  end

  // internal shift time then done rises; no scan load involved
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_cnt_r <= '0;
    end else if (shift_go) begin
      done_cnt_r <= DONE_CYC;
    end else if (state_r == ST_SHIFT && done_cnt_r != 8'd0) begin
      done_cnt_r <= done_cnt_r - 8'd1;
    end
  end

  // done flag rests high, drops at the sampling edge
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_r <= 1'b1;
    end else if (shift_go) begin
      done_r <= 1'b0;
    end else if (state_r == ST_SHIFT && done_cnt_r == 8'd0) begin
      done_r <= 1'b1;
    end
  end
  assign phase_done_o = done_r;

  // sampled select and direction
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_sel_r <= '0;
      last_up_r <= 1'b0;
      shift_pulse_o <= 1'b0;
    end else begin
      shift_pulse_o <= shift_go && sel_ok;
      if (shift_go) begin
        last_sel_r <= in_sync[4:1];
        last_up_r <= in_sync[5];
      end
    end
  end
  assign shift_req_o = '{up: last_up_r, sel: last_sel_r};

  pll_tap_mem #(.ENTRIES(NCTR)) u_taps (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .shift_i(shift_go && sel_ok),
    .up_i(in_sync[5]),
    .sel_i(in_sync[4:1]),
    .rd_idx_i(tap_sel_r),
    .rd_tap_o(tap_rd)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (word_addr == ADDR_LOOP) begin
      rdata_nxt[PUMP_LSB +: 3] = loop_r.pump_current_bits;
      rdata_nxt[RES_LSB +: 5] = loop_r.filter_resistor_bits;
      rdata_nxt[CAP_LSB +: 2] = loop_r.filter_capacitor_bits;
    end else if (word_addr == ADDR_CTR_SEL) begin
      rdata_nxt[3:0] = ctr_sel_r;
    end else if (word_addr == ADDR_CTR_CFG) begin
      if (ctr_sel_r < 4'(NCTR)) begin
        rdata_nxt = {ctr_r[ctr_sel_r].low, ctr_r[ctr_sel_r].high, 6'h00,
                     ctr_r[ctr_sel_r].odd, ctr_r[ctr_sel_r].word};
      end
    end else if (word_addr == ADDR_VCO_DIV) begin
      rdata_nxt[0] = vco_bit_r;
    end else if (word_addr == ADDR_STATUS) begin
      rdata_nxt[9:0] = {bad_code_r, last_up_r, last_sel_r, state_r};
    end else if (word_addr == ADDR_TAP_SEL) begin
      rdata_nxt[3:0] = tap_sel_r;
    end else if (word_addr == ADDR_TAP) begin
      rdata_nxt[2:0] = tap_rd;
    end
  end

  // read data registered; unmapped reads return zero
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_pend_r <= 1'b0;
      avs_readdata_o <= '0;
    end else begin
      rd_pend_r <= avs_read_i & ~rd_pend_r;
      if (avs_read_i) begin
        avs_readdata_o <= rdata_nxt;
      end
    end
  end

endmodule

// ===== test/pll_adjust_asserts.sv
`timescale 1ns/1ps
module pll_adjust_asserts
  import pll_adj_pkg::*;
#(
  parameter int NUM_OUT = 10,
  parameter logic [7:0] DONE_CYC = DONE_DELAY_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // register bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // phase handshake and settings
  input wire logic [3:0] phase_sel_i,
  input wire logic phase_up_i,
  input wire logic phase_step_i,
  input wire logic phase_done_o,
  input wire loop_cfg_type loop_cfg_o,
  input wire logic vco_div_bypass_o,
  input wire logic shift_pulse_o,
  input wire step_req_type shift_req_o
);
  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // full-word writes only, so a masked lane never fakes a field
  logic wr_take;
  logic loop_ok;
  logic [9:0] loop_wd;
  assign wr_take = avs_write_i && !avs_waitrequest_o && avs_byteenable_i == 4'hF;
  assign loop_wd = {avs_writedata_i[2:0], avs_writedata_i[8:4], avs_writedata_i[13:12]};
  assign loop_ok = loop_wd[9:7] inside {3'h0, 3'h1, 3'h3, 3'h7} && loop_wd[1:0] != 2'h2
    && loop_wd[6:2] inside {5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  done_after_reset_a: assert property ($rose(rst_b_i) |-> phase_done_o)
    else $error("done low after reset");
  pulse_done_low_a: assert property (shift_pulse_o |-> !phase_done_o)
    else $error("shift while done high");
  pulse_single_a: assert property (shift_pulse_o |=> !shift_pulse_o)
    else $error("shift pulse too long");
  done_low_time_a: assert property ($fell(phase_done_o) |-> !phase_done_o [*4] ##[1:3] phase_done_o)
    else $error("done low time wrong");
  done_hold_high_a: assert property ($rose(phase_done_o) |-> phase_done_o [*8])
    else $error("done fell too soon");
  step_before_fall_a: assert property ($fell(phase_done_o) |-> phase_step_i && $past(phase_step_i, 8))
    else $error("done fell without step");
  req_sampled_a: assert property (shift_pulse_o |-> shift_req_o == {$past(phase_up_i, 2), $past(phase_sel_i, 2)})
    else $error("shift request wrong");
  loop_apply_a: assert property (wr_take && avs_address_i[5:2] == ADDR_LOOP && loop_ok |=> loop_cfg_o == $past(loop_wd))
    else $error("loop write not applied");
  loop_refuse_a: assert property (wr_take && avs_address_i[5:2] == ADDR_LOOP && !loop_ok |=> $stable(loop_cfg_o))
    else $error("bad loop code applied");
  vco_apply_a: assert property (wr_take && avs_address_i[5:2] == ADDR_VCO_DIV |=> vco_div_bypass_o == !$past(avs_writedata_i[0]))
    else $error("vco bypass wrong");
endmodule

bind pll_adjust_ctrl pll_adjust_asserts #(.NUM_OUT(NUM_OUT), .DONE_CYC(DONE_CYC)) i_chk (
  .core_clk_i, .rst_b_i, .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_waitrequest_o, .phase_sel_i, .phase_up_i, .phase_step_i, .phase_done_o, .loop_cfg_o,
  .vco_div_bypass_o, .shift_pulse_o, .shift_req_o
);

// ===== test/pll_core_user.sv
`timescale 1ns/1ps
module pll_core_user (
  // clock
  input wire logic core_clk_i,
  // handshake
  input wire logic phase_done_i,
  output logic scan_clk_o,
  output logic [3:0] phase_sel_o,
  output logic phase_up_o,
  output logic phase_step_o
);
  // free running scan clock, phase unrelated to the core clock
  initial begin
    scan_clk_o = 1'b0;
    phase_sel_o = 4'h0;
    phase_up_o = 1'b0;
    phase_step_o = 1'b0;
    #137;
    forever #400 scan_clk_o = ~scan_clk_o;
  end

  // one full handshake; inputs are turned round once done proves they were taken
  task automatic do_step(input logic [3:0] sel, input logic up, output bit ok);
    int i;
    int j;
    phase_sel_o <= sel;
    phase_up_o <= up;
    @(negedge scan_clk_o);
    @(posedge core_clk_i);
    phase_step_o <= 1'b1;
    repeat (2) @(posedge scan_clk_o);
    for (i = 0; i < 200 && phase_done_i !== 1'b0; i++) @(negedge core_clk_i);
    @(posedge core_clk_i);
    phase_step_o <= 1'b0;
    phase_sel_o <= ~sel;
    phase_up_o <= ~up;
    for (j = 0; j < 200 && phase_done_i !== 1'b1; j++) @(negedge core_clk_i);
    ok = i < 200 && j < 200;
    @(posedge scan_clk_o);
    @(posedge core_clk_i);
  endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import pll_adj_pkg::*;
  // ----------------------------------------
  // signals and bench state
  // ----------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic scan_clk_i;
  logic [3:0] phase_sel_i;
  logic phase_up_i;
  logic phase_step_i;
  logic phase_done_o;
  loop_cfg_type loop_cfg_o;
  logic [11:0] ctr_bypass_o;
  logic vco_div_bypass_o;
  logic shift_pulse_o;
  step_req_type shift_req_o;
  int n_fail = 0;
  int n_compared = 0;
  int n_pulse = 0;
  logic [31:0] rd;
  logic [9:0] cur;
  logic [11:0] byp;
  logic [2:0] taps [12];
  bit ok;
  // rows {legal, pump, resistor, capacitor}; refused rows sit between good ones
  localparam logic [10:0] ROWS [16] = '{
    11'b1_000_00000_00, 11'b0_010_00000_00, 11'b1_001_00011_01, 11'b0_110_00011_01,
    11'b1_011_00100_11, 11'b0_001_00001_00, 11'b1_111_01000_00, 11'b0_011_10101_01,
    11'b1_000_10000_01, 11'b0_111_00100_10, 11'b1_001_10011_11, 11'b1_011_10100_00,
    11'b1_111_11000_01, 11'b1_000_11011_11, 11'b1_001_11100_00, 11'b1_111_11110_11};

  always #50 core_clk_i = ~core_clk_i;

  pll_adjust_ctrl i_dut (.core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .scan_clk_i, .phase_sel_i, .phase_up_i,
    .phase_step_i, .phase_done_o, .loop_cfg_o, .ctr_bypass_o, .vco_div_bypass_o, .shift_pulse_o, .shift_req_o);
  pll_core_user i_user (.core_clk_i, .phase_done_i(phase_done_o), .scan_clk_o(scan_clk_i),
    .phase_sel_o(phase_sel_i), .phase_up_o(phase_up_i), .phase_step_o(phase_step_i));

  // count shifts away from the launching edge
  always @(negedge core_clk_i) if (shift_pulse_o === 1'b1) n_pulse++;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one bus cycle; read data is taken at the rising edge that sees waitrequest low
  task bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    int i;
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (i == 20) begin
      n_fail++;
      stop_test();
    end
    @(posedge core_clk_i);
  endtask

  function automatic logic [31:0] enc(input logic [9:0] c);
    return {18'h0, c[1:0], 3'h0, c[6:2], 1'b0, c[9:7]};
  endfunction

  // select 0 moves outputs only; taps wrap modulo eight
  task step(input logic [3:0] sel, input logic up);
    int k;
    int p;
    p = n_pulse;
    i_user.do_step(sel, up, ok);
    if (!ok) begin
      n_fail++;
      stop_test();
    end
    chk(n_pulse - p, sel < 4'd12);
    chk(shift_req_o, {up, sel});
    for (k = 1; k < 12; k++) begin
      if (sel == k || (sel == 0 && k > 1)) taps[k] = up ? taps[k] + 3'h1 : taps[k] - 3'h1;
      bus(1'b1, ADDR_TAP_SEL, k);
      bus(1'b0, ADDR_TAP, 32'h0);
      chk(rd, taps[k]);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    chk(phase_done_o, 1'b1);
    chk(ctr_bypass_o, 12'hFFF);
    chk(loop_cfg_o, 10'h000);
    cur = 10'h000;
    for (int r = 0; r < 16; r++) begin
      bus(1'b1, ADDR_LOOP, enc(ROWS[r][9:0]));
      if (ROWS[r][10]) cur = ROWS[r][9:0];
      chk(loop_cfg_o, cur);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[9], !ROWS[r][10]);
      bus(1'b0, ADDR_LOOP, 32'h0);
      chk(rd, enc(cur));
    end
    // counters: clear bypass, read back, then set bypass over junk bits on odd counters
    byp = 12'hFFF;
    for (int k = 0; k < 12; k++) begin
      bus(1'b1, ADDR_CTR_SEL, k);
      bus(1'b1, ADDR_CTR_CFG, {8'(k), 8'(k + 1), 6'h0, 1'(k), 9'h0AA});
      byp[k] = 1'b0;
      chk(ctr_bypass_o, byp);
      bus(1'b0, ADDR_CTR_CFG, 32'h0);
      chk(rd, {8'(k), 8'(k + 1), 6'h0, 1'(k), 9'h0AA});
      if (k % 2 == 1) begin
        bus(1'b1, ADDR_CTR_CFG, 32'hFFFF_FFFF);
        byp[k] = 1'b1;
        chk(ctr_bypass_o, byp);
      end
    end
    bus(1'b1, ADDR_VCO_DIV, 32'h0);
    chk(vco_div_bypass_o, 1'b1);
    bus(1'b1, ADDR_VCO_DIV, 32'h1);
    chk(vco_div_bypass_o, 1'b0);
    // a masked lane writes zero, so the divider falls back to bypass
    avs_byteenable_i <= 4'hE;
    bus(1'b1, ADDR_VCO_DIV, 32'hFFFF_FFFF);
    avs_byteenable_i <= 4'hF;
    chk(vco_div_bypass_o, 1'b1);
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    bus(1'b0, 4'hF, 32'h0);
    chk(rd, 32'h0);
    chk(loop_cfg_o, cur);
    // steps over every select code and one past the end, taps 1 to 11 read back after each
    for (int k = 0; k < 12; k++) taps[k] = 3'h0;
    for (int n = 0; n < 13; n++) step(4'(n), 1'(n));
    // reset in mid-run brings everything back
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    chk(phase_done_o, 1'b1);
    chk(ctr_bypass_o, 12'hFFF);
    chk(loop_cfg_o, 10'h000);
    bus(1'b1, ADDR_TAP_SEL, 32'h2);
    bus(1'b0, ADDR_TAP, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule
